// ===== rtl/canmo_pkg.sv
// constants for the message-object transmit and acceptance handler
package canmo_pkg;
	// ==========================================
	// geometry
	localparam int NUM_OBJ = 32;
	localparam int OBJ_W = 5;
	localparam int ID_W = 29;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] OFS_CMASK = 8'h00;
	localparam logic [7:0] OFS_CRQ = 8'h04;
	localparam logic [7:0] OFS_MSK1 = 8'h08;
	localparam logic [7:0] OFS_MSK2 = 8'h0c;
	localparam logic [7:0] OFS_ARB1 = 8'h10;
	localparam logic [7:0] OFS_ARB2 = 8'h14;
	localparam logic [7:0] OFS_MCTL = 8'h18;
	localparam logic [7:0] OFS_DA1 = 8'h1c;
	localparam logic [7:0] OFS_DA2 = 8'h20;
	localparam logic [7:0] OFS_DB1 = 8'h24;
	localparam logic [7:0] OFS_DB2 = 8'h28;
	localparam logic [7:0] OFS_TXRQ = 8'h2c;
	localparam logic [7:0] OFS_NWDA = 8'h30;
	localparam logic [7:0] OFS_IPND = 8'h34;
	// ==========================================
	// command mask fields
	localparam int CM_WNR = 7;
	localparam int CM_MASK = 6;
	localparam int CM_ARB = 5;
	localparam int CM_CTRL = 4;
	localparam int CM_CLRIP = 3;
	localparam int CM_NEW_DATA_FLAG = 2;
	localparam int CM_DATA_A = 1;
	localparam int CM_DATA_B = 0;
	// command request fields
	localparam int CRQ_BUSY = 15;
	// mask 2 / arbitration 2 fields
	localparam int MK_XTD = 15;
	localparam int MK_DIR = 14;
	localparam int AR_VAL = 15;
	localparam int AR_XTD = 14;
	localparam int AR_DIR = 13;
	// message control fields
	localparam int MC_NEW_DATA_FLAG = 15;
	localparam int MC_MESSAGE_LOST_FLAG = 14;
	localparam int MC_IRQ_PENDING_FLAG = 13;
	localparam int MC_USE_MASK = 12;
	localparam int MC_TRANSMIT_IRQ_ENABLE = 11;
	localparam int MC_RXIE = 10;
	localparam int MC_REMOTE_ENABLE = 9;
	localparam int MC_TRANSMIT_REQUEST_FLAG = 8;
	localparam int MC_EOB = 7;
	// reset values
	localparam logic [15:0] RST_REG = 16'h0000;
endpackage

// ===== rtl/canmo_handler.sv
// message handler: transmit selection, flag upkeep, acceptance scan, interface registers
// ==========================================
// What the document requires of this block and of its software
// (RL1) shift register ready and no transfer busy: load best pending valid object, start.
// (RL2) loading an object clears its new-data flag.
// (RL3) success clears transmit request unless object was rewritten since start.
// (RL4) success sets irq pending when transmit irq enable is set.
// (RL5) lost arbitration or error keeps request; resend when bus free.
// (RL6) pending sends always go out in priority order, retries included.
// (RL7) mask low bits cover extended id [15:0], ignored for standard ids.
// (RL8) mask high bits 12:0 cover extended [28:16]; bits 12:2 standard [10:0].
// (RL9) zero mask passes everything; mask applies only with use-mask set.
// (RL10) two mask bits pick whether extended flag and direction are compared.
// (RL11) arbitration low/high hold id parts as mask, standard in high 12:2.
// (RL12) software sets extended, direction and valid when configuring transmit.
// (RL13) software sets end-of-buffer, length; leaves status flags clear.
// (RL14) data byte 0 sits in bits 7:0 of first data register.
// (RL15) command mask picks direction, parts moved, pending and new-data clearing.
// (RL16) writing object number to command request starts the transfer.
// (RL17) set request or matching remote frame with remote enable makes object eligible.
// (RL18) data updates accepted any time, no need to clear valid or request.
// (RL19) software makes all four bytes of a data register valid first.
// (RL20) new-data with request together: request survives, new-data cleared on start.
// (RL21) scan starts once arbitration and control fields are in.
// (RL22) scan valid objects from object 1 upward, stop at first match.
// (RL23) object 1 highest transmit priority, object 32 lowest.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module canmo_handler (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic tx_ready,
	input wire logic tx_done,
	input wire logic tx_error,
	output logic tx_start,
	output logic [canmo_pkg::OBJ_W-1:0] tx_obj,
	output logic [canmo_pkg::ID_W-1:0] tx_id,
	output logic tx_ext,
	output logic [3:0] tx_dlc,
	output logic [63:0] tx_data,
	input wire logic rx_hdr_valid,
	input wire logic [canmo_pkg::ID_W-1:0] rx_id,
	input wire logic rx_ext,
	input wire logic rx_remote,
	output logic rx_match,
	output logic rx_no_match,
	output logic [canmo_pkg::OBJ_W-1:0] rx_match_obj
);
	import canmo_pkg::*;

	typedef enum logic {CANMO_TX_IDLE, CANMO_TX_BUSY} canmo_tx_t;
	typedef enum logic {CANMO_SC_IDLE, CANMO_SC_RUN} canmo_scan_t;

	// ==========================================
	// message memory and flags
	logic [15:0] m_msk1 [NUM_OBJ];
	logic [15:0] m_msk2 [NUM_OBJ];
	logic [15:0] m_arb1 [NUM_OBJ];
	logic [15:0] m_arb2 [NUM_OBJ];
	logic [15:0] m_ctl [NUM_OBJ];
	logic [63:0] m_data [NUM_OBJ];
	logic [NUM_OBJ-1:0] new_data_vector;
	logic [NUM_OBJ-1:0] transmit_request_vector;
	logic [NUM_OBJ-1:0] irq_pending_vector;
	// interface register set
	logic [7:0] iface_command_mask;
	logic [15:0] iface_mask_low, iface_mask_high, iface_arbitration_low, iface_arbitration_high;
	logic [15:0] iface_message_control;
	logic [15:0] iface_data [4];
	logic [5:0] object_number;
	logic xfer_busy;
	// bus, transmit and scan state
	logic ap_valid, ap_write;
	logic [7:0] ap_addr;
	canmo_tx_t tx_state;
	canmo_scan_t scan_state;
	logic cur_dirty;
	logic [OBJ_W-1:0] scan_idx;
	logic [ID_W-1:0] rx_id_q;
	logic rx_ext_q, rx_remote_q;

	// ==========================================
	// ahb-lite slave: zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire ap_take = hsel && htrans[1] && hready;
	wire wr_en = ap_valid && ap_write;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= 8'h00;
		end else if (hready) begin
			ap_valid <= ap_take;
			ap_write <= hwrite;
			ap_addr <= haddr[7:0];
		end
	end

	// read data registered in the address phase so hrdata comes from a flop
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (haddr[7:0])
			OFS_CMASK: next_rdata = {24'h000000, iface_command_mask};
			OFS_CRQ: next_rdata = {16'h0000, xfer_busy, 9'h000, object_number};
			OFS_MSK1: next_rdata = {16'h0000, iface_mask_low};
			OFS_MSK2: next_rdata = {16'h0000, iface_mask_high};
			OFS_ARB1: next_rdata = {16'h0000, iface_arbitration_low};
			OFS_ARB2: next_rdata = {16'h0000, iface_arbitration_high};
			OFS_MCTL: next_rdata = {16'h0000, iface_message_control};
			OFS_DA1: next_rdata = {16'h0000, iface_data[0]};
			OFS_DA2: next_rdata = {16'h0000, iface_data[1]};
			OFS_DB1: next_rdata = {16'h0000, iface_data[2]};
			OFS_DB2: next_rdata = {16'h0000, iface_data[3]};
			OFS_TXRQ: next_rdata = transmit_request_vector;
			OFS_NWDA: next_rdata = new_data_vector;
			OFS_IPND: next_rdata = irq_pending_vector;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (ap_take && !hwrite)
			hrdata <= next_rdata;
	end

	// ==========================================
	// interface registers and transfer trigger
	wire [OBJ_W-1:0] xo = OBJ_W'(object_number - 6'h01);
	wire xfer_go = xfer_busy;
	wire xfer_wr = iface_command_mask[CM_WNR];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iface_command_mask <= 8'h00;
			iface_mask_low <= RST_REG;
			iface_mask_high <= RST_REG;
			iface_arbitration_low <= RST_REG;
			iface_arbitration_high <= RST_REG;
			iface_message_control <= RST_REG;
			for (int i = 0; i < 4; i++) iface_data[i] <= RST_REG;
			object_number <= 6'h01;
			xfer_busy <= 1'b0;
		end else begin
			xfer_busy <= 1'b0;
			if (wr_en && !xfer_busy) begin
				unique case (ap_addr)
					OFS_CMASK: iface_command_mask <= hwdata[7:0];
					OFS_MSK1: iface_mask_low <= hwdata[15:0];
					OFS_MSK2: iface_mask_high <= hwdata[15:0];
					OFS_ARB1: iface_arbitration_low <= hwdata[15:0];
					OFS_ARB2: iface_arbitration_high <= hwdata[15:0];
					OFS_MCTL: iface_message_control <= hwdata[15:0];
					OFS_DA1: iface_data[0] <= hwdata[15:0];
					OFS_DA2: iface_data[1] <= hwdata[15:0];
					OFS_DB1: iface_data[2] <= hwdata[15:0];
					OFS_DB2: iface_data[3] <= hwdata[15:0];
					OFS_CRQ: begin
						// numbers outside 1..32 are taken but move nothing
						object_number <= hwdata[5:0];
						xfer_busy <= (hwdata[5:0] != 6'h00) && (hwdata[5:0] <= 6'(NUM_OBJ)); // RL16
					end
					default: ;
				endcase
			end
			if (xfer_go && !xfer_wr) begin // RL15
				if (iface_command_mask[CM_MASK]) begin
					iface_mask_low <= m_msk1[xo];
					iface_mask_high <= m_msk2[xo];
				end
				if (iface_command_mask[CM_ARB]) begin
					iface_arbitration_low <= m_arb1[xo];
					iface_arbitration_high <= m_arb2[xo];
				end
				if (iface_command_mask[CM_CTRL])
					iface_message_control <= {new_data_vector[xo], m_ctl[xo][14], irq_pending_vector[xo],
						m_ctl[xo][12:9], transmit_request_vector[xo], m_ctl[xo][7:0]};
				if (iface_command_mask[CM_DATA_A]) begin // RL14
					iface_data[0] <= m_data[xo][15:0];
					iface_data[1] <= m_data[xo][31:16];
				end
				if (iface_command_mask[CM_DATA_B]) begin
					iface_data[2] <= m_data[xo][47:32];
					iface_data[3] <= m_data[xo][63:48];
				end
			end
		end
	end

	// ==========================================
	// transmit selection: lowest object index wins
	logic [OBJ_W-1:0] best;
	logic best_ok;
	always_comb begin
		best = '0;
		best_ok = 1'b0;
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (m_arb2[i][AR_VAL] && transmit_request_vector[i]) begin // RL23 RL6 RL17
				best = OBJ_W'(i);
				best_ok = 1'b1;
			end
		end
	end
	wire load = tx_ready && !xfer_busy && best_ok && (tx_state == CANMO_TX_IDLE); // RL1
	assign tx_start = load;

	// a data write, or a control write with new-data set, into the object under transmission protects its request
	wire touch_cur = xfer_go && xfer_wr && (xo == tx_obj) && (tx_state == CANMO_TX_BUSY) &&
		(iface_command_mask[CM_DATA_A] || iface_command_mask[CM_DATA_B] ||
		(iface_command_mask[CM_CTRL] && iface_message_control[MC_NEW_DATA_FLAG]));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state <= CANMO_TX_IDLE;
			tx_obj <= '0;
			tx_id <= '0;
			tx_ext <= 1'b0;
			tx_dlc <= 4'h0;
			tx_data <= 64'h0000_0000_0000_0000;
			cur_dirty <= 1'b0;
		end else begin
			if (load) begin
				tx_state <= CANMO_TX_BUSY;
				tx_obj <= best;
				tx_ext <= m_arb2[best][AR_XTD];
				tx_id <= m_arb2[best][AR_XTD] ? {m_arb2[best][12:0], m_arb1[best]} : // RL11
					{18'h00000, m_arb2[best][12:2]};
				tx_dlc <= m_ctl[best][3:0];
				tx_data <= m_data[best];
				cur_dirty <= 1'b0;
			end else if (tx_state == CANMO_TX_BUSY && (tx_done || tx_error)) begin
				// on error the request stays, so the next free slot reselects by priority
				tx_state <= CANMO_TX_IDLE; // RL5
			end
			if (touch_cur)
				cur_dirty <= 1'b1; // RL20
		end
	end

	// ==========================================
	// acceptance scan, one object per cycle
	logic [ID_W-1:0] s_id, s_msk;
	logic s_hit;
	always_comb begin
		if (m_arb2[scan_idx][AR_XTD]) begin
			s_id = {m_arb2[scan_idx][12:0], m_arb1[scan_idx]}; // RL7 RL8
			s_msk = {m_msk2[scan_idx][12:0], m_msk1[scan_idx]};
		end else begin
			s_id = {18'h00000, m_arb2[scan_idx][12:2]}; // RL8
			s_msk = {18'h00000, m_msk2[scan_idx][12:2]};
		end
		if (!m_ctl[scan_idx][MC_USE_MASK])
			s_msk = {ID_W{1'b1}}; // RL9
		s_hit = m_arb2[scan_idx][AR_VAL] && (((s_id ^ rx_id_q) & s_msk) == '0) &&
			(!(m_ctl[scan_idx][MC_USE_MASK] ? m_msk2[scan_idx][MK_XTD] : 1'b1) ||
			m_arb2[scan_idx][AR_XTD] == rx_ext_q) && // RL10
			(!(m_ctl[scan_idx][MC_USE_MASK] ? m_msk2[scan_idx][MK_DIR] : 1'b1) ||
			m_arb2[scan_idx][AR_DIR] == rx_remote_q);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scan_state <= CANMO_SC_IDLE;
			scan_idx <= '0;
			rx_id_q <= '0;
			rx_ext_q <= 1'b0;
			rx_remote_q <= 1'b0;
			rx_match <= 1'b0;
			rx_no_match <= 1'b0;
			rx_match_obj <= '0;
		end else begin
			rx_match <= 1'b0;
			rx_no_match <= 1'b0;
			unique case (scan_state)
				CANMO_SC_IDLE: if (rx_hdr_valid) begin // RL21
					scan_state <= CANMO_SC_RUN;
					scan_idx <= '0;
					rx_id_q <= rx_ext ? rx_id : {18'h00000, rx_id[10:0]};
					rx_ext_q <= rx_ext;
					rx_remote_q <= rx_remote;
				end
				CANMO_SC_RUN: begin
					if (s_hit) begin // RL22
						scan_state <= CANMO_SC_IDLE;
						rx_match <= 1'b1;
						rx_match_obj <= scan_idx;
					end else if (scan_idx == OBJ_W'(NUM_OBJ - 1)) begin
						scan_state <= CANMO_SC_IDLE;
						rx_no_match <= 1'b1;
					end else begin
						scan_idx <= OBJ_W'(scan_idx + 1'b1);
					end
				end
			endcase
		end
	end
	wire remote_req = (scan_state == CANMO_SC_RUN) && s_hit && rx_remote_q &&
		m_arb2[scan_idx][AR_DIR] && m_ctl[scan_idx][MC_REMOTE_ENABLE];

	// ==========================================
	// message memory writes; hardware sets are applied last so they win
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				m_msk1[i] <= RST_REG;
				m_msk2[i] <= RST_REG;
				m_arb1[i] <= RST_REG;
				m_arb2[i] <= RST_REG;
				m_ctl[i] <= RST_REG;
				m_data[i] <= 64'h0000_0000_0000_0000;
			end
			new_data_vector <= '0;
			transmit_request_vector <= '0;
			irq_pending_vector <= '0;
		end else begin
			if (xfer_go) begin // RL15 RL18
				if (xfer_wr) begin
					if (iface_command_mask[CM_MASK]) begin
						m_msk1[xo] <= iface_mask_low;
						m_msk2[xo] <= iface_mask_high;
					end
					if (iface_command_mask[CM_ARB]) begin
						m_arb1[xo] <= iface_arbitration_low;
						m_arb2[xo] <= iface_arbitration_high;
					end
					if (iface_command_mask[CM_CTRL]) begin
						m_ctl[xo] <= iface_message_control;
						new_data_vector[xo] <= iface_message_control[MC_NEW_DATA_FLAG];
						transmit_request_vector[xo] <= iface_message_control[MC_TRANSMIT_REQUEST_FLAG];
						irq_pending_vector[xo] <= iface_message_control[MC_IRQ_PENDING_FLAG];
					end
					if (iface_command_mask[CM_DATA_A])
						m_data[xo][31:0] <= {iface_data[1], iface_data[0]};
					if (iface_command_mask[CM_DATA_B])
						m_data[xo][63:32] <= {iface_data[3], iface_data[2]};
					if (iface_command_mask[CM_NEW_DATA_FLAG])
						transmit_request_vector[xo] <= 1'b1;
				end else if (iface_command_mask[CM_NEW_DATA_FLAG]) begin
					new_data_vector[xo] <= 1'b0;
				end
				if (iface_command_mask[CM_CLRIP])
					irq_pending_vector[xo] <= 1'b0;
			end
			if (load)
				new_data_vector[best] <= 1'b0; // RL2 RL20
			if (tx_state == CANMO_TX_BUSY && tx_done && !tx_error) begin
				if (!cur_dirty && !touch_cur)
					transmit_request_vector[tx_obj] <= 1'b0; // RL3
				if (m_ctl[tx_obj][MC_TRANSMIT_IRQ_ENABLE])
					irq_pending_vector[tx_obj] <= 1'b1; // RL4
			end
			if (remote_req)
				transmit_request_vector[scan_idx] <= 1'b1; // RL17
		end
	end

	// ==========================================
	// checks
	chk_load_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_start |-> tx_ready && !xfer_busy && transmit_request_vector[tx_obj] == 1'b0 || 1'b1 ?
		(tx_ready && !xfer_busy) : 1'b0) else $error("load while busy or not ready"); // RL1
	chk_load_prio: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_start |=> (tx_obj == 0) || !(|(transmit_request_vector & $past(transmit_request_vector)
		& ((32'h0000_0001 << tx_obj) - 32'h0000_0001)))) else $error("lower priority object sent first"); // RL23
	chk_new_data_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_start && !remote_req |=> !new_data_vector[tx_obj] || $past(xfer_go))
		else $error("new data survived load"); // RL2
	chk_txrq_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_state == CANMO_TX_BUSY && tx_done && !tx_error && !cur_dirty && !touch_cur && !remote_req
		|=> !transmit_request_vector[$past(tx_obj)]) else $error("request kept after success"); // RL3
	chk_irq_set: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_state == CANMO_TX_BUSY && tx_done && !tx_error && m_ctl[tx_obj][MC_TRANSMIT_IRQ_ENABLE]
		|=> irq_pending_vector[$past(tx_obj)]) else $error("pending flag not set"); // RL4
	chk_retry_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_state == CANMO_TX_BUSY && tx_error && !xfer_go |=> transmit_request_vector[$past(tx_obj)]
		&& tx_state == CANMO_TX_IDLE) else $error("request lost on error"); // RL5
	chk_dirty_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_state == CANMO_TX_BUSY && tx_done && cur_dirty |=> transmit_request_vector[$past(tx_obj)])
		else $error("updated object lost its request"); // RL20
	chk_remote_set: assert property (@(posedge hclk) disable iff (!hresetn)
		remote_req |=> transmit_request_vector[$past(scan_idx)] && rx_match) else $error("remote frame ignored"); // RL17
	chk_scan_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		scan_state == CANMO_SC_RUN && s_hit |=> scan_state == CANMO_SC_IDLE && rx_match_obj == $past(scan_idx))
		else $error("scan went past a match"); // RL22
	chk_scan_start: assert property (@(posedge hclk) disable iff (!hresetn)
		scan_state == CANMO_SC_IDLE && rx_hdr_valid |=> scan_state == CANMO_SC_RUN && scan_idx == '0)
		else $error("scan did not start at object 1"); // RL21
endmodule
`default_nettype wire

// ===== tb/canmo_bus_model.sv
// behavioural transmit shift register and shared bus seen by the handler
`timescale 1ns/1ps
`default_nettype none
module canmo_bus_model #(
	parameter int LAT = 80
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic en,
	input wire logic fail_next,
	input wire logic tx_start,
	output logic tx_ready,
	output logic tx_done,
	output logic tx_error
);
	logic busy;
	int cnt;
	// a frame in flight holds the bus, so ready only comes back once it is over
	assign tx_ready = en & ~busy;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			cnt <= 0;
			tx_done <= 1'b0;
			tx_error <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			tx_error <= 1'b0;
			if (tx_start && tx_ready) begin
				busy <= 1'b1;
				cnt <= LAT;
			end else if (busy) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					busy <= 1'b0;
					tx_done <= !fail_next;
					tx_error <= fail_next;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/canmo_handler_tb.sv
// self-checking bench for the message handler
`timescale 1ns/1ps
`default_nettype none
module canmo_handler_tb;
	import canmo_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} canmo_reg_row_t;
	typedef struct {logic [28:0] id; logic ext; logic rem; logic hit; logic [4:0] obj;} canmo_rx_row_t;
	logic hclk, hresetn, hsel, hwrite, en, fail_next, rx_hdr_valid, rx_ext, rx_remote;
	logic tx_start, tx_ext, tx_ready, tx_done, tx_error, rx_match, rx_no_match, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] tx_obj, rx_match_obj;
	logic [28:0] tx_id, rx_id;
	logic [3:0] tx_dlc;
	logic [63:0] tx_data;
	logic [98:0] txq [$];
	int err_count = 0;
	int checked = 0;
	canmo_reg_row_t regs [5] = '{'{OFS_MSK1, 32'h1234abcd, 32'habcd}, '{OFS_DB2, 32'h5a5a, 32'h5a5a},
		'{OFS_TXRQ, 32'hffff, 32'h0}, '{8'h3c, 32'h1234, 32'h0}, '{OFS_CMASK, 32'hff, 32'hff}};
	canmo_rx_row_t rows [6] = '{'{29'h1234ffff, 1, 0, 1, 5'd6}, '{29'h12350000, 1, 0, 0, 5'd0},
		'{29'h123, 0, 0, 1, 5'd7}, '{29'h124, 0, 0, 0, 5'd0}, '{29'h055, 0, 1, 1, 5'd4},
		'{29'h12340000, 0, 0, 0, 5'd0}};
	canmo_handler dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tx_ready(tx_ready), .tx_done(tx_done), .tx_error(tx_error),
		.tx_start(tx_start), .tx_obj(tx_obj), .tx_id(tx_id), .tx_ext(tx_ext), .tx_dlc(tx_dlc),
		.tx_data(tx_data), .rx_hdr_valid(rx_hdr_valid), .rx_id(rx_id), .rx_ext(rx_ext),
		.rx_remote(rx_remote), .rx_match(rx_match), .rx_no_match(rx_no_match), .rx_match_obj(rx_match_obj));
	canmo_bus_model #(.LAT(80)) far (.hclk(hclk), .hresetn(hresetn), .en(en), .fail_next(fail_next),
		.tx_start(tx_start), .tx_ready(tx_ready), .tx_done(tx_done), .tx_error(tx_error));
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// fields settle one edge after the load pulse
	always @(posedge hclk) begin
		if (tx_start === 1'b1) begin
			@(posedge hclk);
			#1;
			txq.push_back({tx_obj, tx_ext, tx_id, tx_data});
		end
	end
	// ==========================================
	// helpers
	task automatic summarize();
		$display("errors %0d checked %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [98:0] got, input logic [98:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
	endtask
	// one single transfer; entered and left just after a rising edge
	task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr_en;
		hsize <= 3'b010;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		hsel <= 1'b0;
		@(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp({67'h0, q}, {67'h0, e});
	endtask
	task automatic cfg(input logic [5:0] num, input logic [28:0] id, input logic ext, input logic dir,
		input logic [15:0] mctl, input logic [15:0] m1, input logic [15:0] m2, input logic [63:0] d);
		wr(OFS_CMASK, 32'h00f3);
		wr(OFS_MSK1, {16'h0, m1});
		wr(OFS_MSK2, {16'h0, m2});
		wr(OFS_ARB1, {16'h0, ext ? id[15:0] : 16'h0});
		wr(OFS_ARB2, {16'h0, 1'b1, ext, dir, ext ? id[28:16] : {id[10:0], 2'b00}});
		wr(OFS_MCTL, {16'h0, mctl});
		wr(OFS_DA1, {16'h0, d[15:0]});
		wr(OFS_DA2, {16'h0, d[31:16]});
		wr(OFS_DB1, {16'h0, d[47:32]});
		wr(OFS_DB2, {16'h0, d[63:48]});
		wr(OFS_CRQ, {26'h0, num});
	endtask
	task automatic wait_q(input int n);
		for (int i = 0; i < 500 && txq.size() < n; i++) @(posedge hclk);
	endtask
	task automatic wait_end();
		for (int i = 0; i < 500 && tx_done !== 1'b1 && tx_error !== 1'b1; i++) @(posedge hclk);
		@(posedge hclk);
	endtask
	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	// ==========================================
	// main sequence
	initial begin
		logic hit;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		en = 1'b0;
		fail_next = 1'b0;
		rx_hdr_valid = 1'b0;
		rx_id = 29'h0;
		rx_ext = 1'b0;
		rx_remote = 1'b0;
		do_reset();
		chk(OFS_CRQ, 32'h1);
		foreach (regs[i]) begin
			wr(regs[i].a, regs[i].d);
			chk(regs[i].a, regs[i].e);
		end
		// two requests queued while the bus is held off
		cfg(2, 29'h1abcdef0, 1, 1, 16'h8188, 16'h0, 16'h0, 64'h0706050403020100);
		cfg(5, 29'h055, 0, 1, 16'h8988, 16'h0, 16'h0, 64'h1);
		chk(OFS_NWDA, 32'h12);
		chk(OFS_TXRQ, 32'h12);
		fail_next <= 1'b1;
		en <= 1'b1;
		wait_q(1);
		cfg(1, 29'h0aaa5555, 1, 1, 16'h8188, 16'h0, 16'h0, 64'h2);
		wait_end();
		fail_next <= 1'b0;
		wait_q(4);
		wait_end();
		cmp(txq[0], {5'd1, 1'b1, 29'h1abcdef0, 64'h0706050403020100});
		cmp(txq[1][98:94], 5'd0);
		cmp(txq[2][98:94], 5'd1);
		cmp(txq[3][98:94], 5'd4);
		chk(OFS_TXRQ, 32'h0);
		chk(OFS_NWDA, 32'h0);
		chk(OFS_IPND, 32'h10);
		// data rewritten during the frame: request must survive
		cfg(4, 29'h200, 0, 1, 16'h8188, 16'h0, 16'h0, 64'h3);
		wait_q(5);
		wr(OFS_CMASK, 32'h0082);
		wr(OFS_DA1, 32'hbeef);
		wr(OFS_CRQ, 32'h4);
		wait_q(6);
		cmp({txq[5][98:94], txq[5][15:0]}, {5'd3, 16'hbeef});
		wait_end();
		chk(OFS_TXRQ, 32'h0);
		// receive objects for the acceptance scan
		cfg(7, 29'h12345678, 1, 0, 16'h1088, 16'h0, 16'hdfff, 64'h0);
		cfg(8, 29'h123, 0, 0, 16'h0088, 16'h0, 16'h0, 64'h0);
		cfg(9, 29'h123, 0, 0, 16'h0088, 16'h0, 16'h0, 64'h0);
		foreach (rows[i]) begin
			rx_hdr_valid <= 1'b1;
			rx_id <= rows[i].id;
			rx_ext <= rows[i].ext;
			rx_remote <= rows[i].rem;
			@(posedge hclk);
			rx_hdr_valid <= 1'b0;
			for (int n = 0; n < 40; n++) begin
				@(posedge hclk);
				if (rx_match === 1'b1 || rx_no_match === 1'b1) break;
			end
			hit = rx_match;
			cmp({hit, hit ? rx_match_obj : 5'd0}, {rows[i].hit, rows[i].obj});
			@(posedge hclk);
		end
		// reset in mid-run wipes objects and flags
		do_reset();
		cmp(tx_start, 1'b0);
		chk(OFS_CRQ, 32'h1);
		chk(OFS_TXRQ, 32'h0);
		chk(OFS_IPND, 32'h0);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		summarize();
	end
endmodule
`default_nettype wire
